// File: common/dual_timer_cfg.svh
// register offsets, bit positions, reset values and function codes of the timer pair
`ifndef DUAL_TIMER_CFG_SVH
`define DUAL_TIMER_CFG_SVH

// ==========================================================
// register offsets
`define REG_LOW_CTRL 2'h0
`define REG_HIGH_CTRL 2'h1
`define REG_LOW_DATA 2'h2
`define REG_HIGH_DATA 2'h3

// ==========================================================
// status control bit positions
`define BIT_RUN 7
`define BIT_SUSPEND 6
`define BIT_IRQ_EN 5
`define BIT_CAPTURE_DONE 4
`define BIT_RESULT_HELD 3
`define BIT_OVF_MATCH 2
`define BIT_INIT_LEVEL 1
`define BIT_PIN_DRIVE 0

// ==========================================================
// reset values
`define CTRL_BIT_RESET 1'b0
`define DATA_RESET 8'h00
`define READ_IDLE 8'h00

// ==========================================================
// function select codes and groups
`define FS_PWM_VAR 4'h4
`define FS_PWC_HIGH_CYCLE 4'h9
`define FS_GROUP_PWC 2'h2
`define FS_GROUP_CAPTURE 2'h3
`define FS_GROUP_INTERVAL 3'h0

`endif

// File: common/dual_timer_pkg.sv
// types shared by the timer pair status control logic
package dual_timer_pkg;

    // ==========================================================
    // types
    typedef logic [3:0] func_sel_t;
    typedef logic [7:0] byte_t;
    typedef logic [1:0] reg_addr_t;

endpackage : dual_timer_pkg

// File: design/dual_timer_status_control.sv
// run, suspend, flag, output and interrupt control of an 8-bit timer pair with 16-bit cascade
//
// Decided for this implementation: the address map and the plain strobed port.
`include "dual_timer_cfg.svh"

module dual_timer_status_control
    import dual_timer_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire reg_addr_t reg_addr,
    input wire byte_t reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic reg_read_rmw,
    output byte_t reg_rdata,
    input wire func_sel_t function_select_low,
    input wire func_sel_t function_select_high,
    input wire logic [1:0] overflow_irq_gate,
    input wire logic width_select_16,
    input wire logic [1:0] measure_done,
    input wire logic [1:0] measure_high_pulse,
    input wire logic [1:0] capture_edge,
    input wire logic [1:0] count_match,
    input wire logic [1:0] count_overflow,
    input wire logic [15:0] measured_count,
    input wire logic [1:0] out_toggle,
    input wire logic [1:0] gpio_out,
    input wire logic [1:0] gpio_oe,
    output logic [1:0] count_enable,
    output logic [1:0] count_clear,
    output logic [15:0] compare_capture_data,
    output logic [1:0] timer_out_level,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe,
    output logic [1:0] irq
);

    // ==========================================================
    // mode decode
    function automatic logic is_pwc(input func_sel_t f);
        return f[3:2] == `FS_GROUP_PWC;
    endfunction : is_pwc

    function automatic logic is_capture(input func_sel_t f);
        return f[3:2] == `FS_GROUP_CAPTURE;
    endfunction : is_capture

    function automatic logic is_interval(input func_sel_t f);
        return f[3:1] == `FS_GROUP_INTERVAL;
    endfunction : is_interval

    function automatic logic is_pwm_var(input func_sel_t f);
        return f == `FS_PWM_VAR;
    endfunction : is_pwm_var

    func_sel_t fs [2];
    logic pwm_pair;
    logic cascade;
    logic [1:0] wr_ctrl;
    logic [1:0] rd_data;
    logic [1:0] ir_event;
    logic [1:0] store_ok;

    assign fs[0] = function_select_low;
    assign fs[1] = function_select_high;
    assign pwm_pair = is_pwm_var(fs[0]) | is_pwm_var(fs[1]);
    assign cascade = width_select_16;
    assign wr_ctrl[0] = reg_write && (reg_addr == `REG_LOW_CTRL);
    assign wr_ctrl[1] = reg_write && (reg_addr == `REG_HIGH_CTRL);
    assign rd_data[0] = reg_read && (reg_addr == `REG_LOW_DATA);
    assign rd_data[1] = reg_read && (reg_addr == `REG_HIGH_DATA);

    // ==========================================================
    // control and flag state
    logic [1:0] run;
    logic [1:0] susp;
    logic [1:0] ie;
    logic [1:0] ir;
    logic [1:0] bf;
    logic [1:0] flag;
    logic [1:0] so;
    logic [1:0] oe;
    byte_t data [2];
    logic [1:0] out_lvl;
    byte_t rdata;
    logic [1:0] next_run;
    logic [1:0] next_susp;
    logic [1:0] next_ie;
    logic [1:0] next_ir;
    logic [1:0] next_bf;
    logic [1:0] next_flag;
    logic [1:0] next_so;
    logic [1:0] next_oe;
    byte_t next_data [2];
    logic [1:0] next_out_lvl;
    byte_t next_rdata;

    always_comb begin
        next_run = run;
        next_susp = susp;
        next_ie = ie;
        next_ir = ir;
        next_bf = bf;
        next_flag = flag;
        next_so = so;
        next_oe = oe;
        next_data = data;
        next_out_lvl = out_lvl;
        ir_event = 2'b00;
        store_ok = 2'b00;
        for (int i = 0; i < 2; i++) begin
            ir_event[i] = (is_pwc(fs[i]) & measure_done[i]) | (is_capture(fs[i]) & capture_edge[i]);
            // a held result blocks a new one, except the high pulse of the combined code
            store_ok[i] = measure_done[i] & is_pwc(fs[i]) &
                          (!bf[i] | ((fs[i] == `FS_PWC_HIGH_CYCLE) & measure_high_pulse[i]));
        end
        for (int i = 0; i < 2; i++) begin
            if (wr_ctrl[i]) begin
                next_run[i] = reg_wdata[`BIT_RUN];
                next_susp[i] = reg_wdata[`BIT_SUSPEND];
                next_ie[i] = reg_wdata[`BIT_IRQ_EN];
                next_oe[i] = reg_wdata[`BIT_PIN_DRIVE];
            end
            if (wr_ctrl[1 - i] && !reg_wdata[`BIT_RUN] && (pwm_pair || cascade)) begin
                next_run[i] = 1'b0;
            end
            if (wr_ctrl[1 - i] && reg_wdata[`BIT_RUN] && pwm_pair) begin
                next_run[i] = 1'b1;
            end
            if (wr_ctrl[1 - i] && (pwm_pair || cascade)) begin
                next_susp[i] = reg_wdata[`BIT_SUSPEND];
            end
            if (wr_ctrl[i] && (!(run[0] | run[1]) || (i == 1 && cascade))) begin
                next_so[i] = reg_wdata[`BIT_INIT_LEVEL];
            end
            // flags: clear first, so a same-cycle event wins
            if (wr_ctrl[i] && !reg_wdata[`BIT_CAPTURE_DONE]) begin
                next_ir[i] = 1'b0;
            end
            if (ir_event[i]) begin
                next_ir[i] = 1'b1;
            end
            if (!(is_pwc(fs[i]) | is_capture(fs[i])) || (i == 1 && cascade)) begin
                next_ir[i] = 1'b0;
            end
            if (wr_ctrl[i] && !reg_wdata[`BIT_OVF_MATCH]) begin
                next_flag[i] = 1'b0;
            end
            if ((is_interval(fs[i]) & count_match[i]) |
                ((is_pwc(fs[i]) | is_capture(fs[i])) & count_overflow[i])) begin
                next_flag[i] = 1'b1;
            end
            if (is_pwm_var(fs[i]) || (i == 1 && cascade)) begin
                next_flag[i] = 1'b0;
            end
            // result held: data reads clear (in cascade only the high data read), stores set, and writes never touch it
            if (!cascade && rd_data[i]) begin
                next_bf[i] = 1'b0;
            end
            if (cascade && i == 0 && rd_data[1]) begin
                next_bf[i] = 1'b0;
            end
            if (store_ok[i] && !(i == 1 && cascade)) begin
                next_bf[i] = 1'b1;
            end
            if (!is_pwc(fs[i]) || (i == 1 && cascade)) begin
                next_bf[i] = 1'b0;
            end
            if (cascade ? store_ok[0] : store_ok[i]) begin
                next_data[i] = measured_count[i * 8 +: 8];
            end
            if (!run[i] && next_run[i]) begin
                next_out_lvl[i] = cascade ? next_so[0] : next_so[i];
            end else if (run[i] && out_toggle[i]) begin
                next_out_lvl[i] = !out_lvl[i];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            run <= {2{`CTRL_BIT_RESET}};
            susp <= {2{`CTRL_BIT_RESET}};
            ie <= {2{`CTRL_BIT_RESET}};
            ir <= {2{`CTRL_BIT_RESET}};
            bf <= {2{`CTRL_BIT_RESET}};
            flag <= {2{`CTRL_BIT_RESET}};
            so <= {2{`CTRL_BIT_RESET}};
            oe <= {2{`CTRL_BIT_RESET}};
            data[0] <= `DATA_RESET;
            data[1] <= `DATA_RESET;
            out_lvl <= {2{`CTRL_BIT_RESET}};
        end else begin
            run <= next_run;
            susp <= next_susp;
            ie <= next_ie;
            ir <= next_ir;
            bf <= next_bf;
            flag <= next_flag;
            so <= next_so;
            oe <= next_oe;
            data <= next_data;
            out_lvl <= next_out_lvl;
        end
    end

    // ==========================================================
    // register read port
    always_comb begin
        next_rdata = `READ_IDLE;
        if (reg_read) begin
            case (reg_addr)
                `REG_LOW_CTRL, `REG_HIGH_CTRL: begin
                    // rmw reads see ones so a write-back never clears a flag by accident
                    next_rdata = {run[reg_addr[0]], susp[reg_addr[0]], ie[reg_addr[0]],
                                  ir[reg_addr[0]] | reg_read_rmw, bf[reg_addr[0]],
                                  flag[reg_addr[0]] | reg_read_rmw,
                                  so[reg_addr[0]], oe[reg_addr[0]]};
                end
                `REG_LOW_DATA: begin
                    next_rdata = data[0];
                end
                `REG_HIGH_DATA: begin
                    next_rdata = data[1];
                end
                default: begin
                    next_rdata = `READ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= `READ_IDLE;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ==========================================================
    // outputs
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            // in cascade the upper half follows the low timer's run and suspend
            count_enable[i] = cascade ? (run[0] & !susp[0]) : (run[i] & !susp[i]);
            count_clear[i] = cascade ? !run[0] : !run[i];
            irq[i] = ie[i] & (ir[i] | (flag[i] & overflow_irq_gate[i]));
            pin_out[i] = oe[i] ? out_lvl[i] : gpio_out[i];
            pin_oe[i] = oe[i] ? 1'b1 : gpio_oe[i];
        end
    end

    assign reg_rdata = rdata;
    assign compare_capture_data = {data[1], data[0]};
    assign timer_out_level = out_lvl;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_stop_clears: assert property (wr_ctrl[0] && !reg_wdata[7] |=> !run[0] && count_clear[0])
        else $error("run write zero did not stop and clear");
    a_start_counts: assert property (wr_ctrl[0] && reg_wdata[7:6] == 2'b10 |=> count_enable[0] && !count_clear[0])
        else $error("run write one did not start counting");
    a_pwm_run_link: assert property (pwm_pair && (wr_ctrl[0] || wr_ctrl[1]) && !reg_wdata[7] |=> run == 2'b00)
        else $error("variable pwm stop not mirrored");
    a_cascade_stop: assert property (cascade && (wr_ctrl[0] || wr_ctrl[1]) && !reg_wdata[7]
                                     |=> run == 2'b00 && count_enable == 2'b00)
        else $error("cascade stop not mirrored to upper");
    a_suspend_freeze: assert property (wr_ctrl[0] && reg_wdata[6] && !cascade |=> !count_enable[0])
        else $error("suspend did not freeze counting");
    a_suspend_link: assert property ((pwm_pair || cascade) && wr_ctrl[1] |=> susp[0] == $past(reg_wdata[6]))
        else $error("suspend not mirrored in linked mode");
    a_irq_capture: assert property (ie[0] && ir[0] |-> irq[0])
        else $error("capture flag did not raise interrupt");
    a_irq_gated: assert property (flag[0] && !ir[0] && !overflow_irq_gate[0] |-> !irq[0])
        else $error("ungated overflow raised interrupt");
    a_capture_set: assert property (is_capture(fs[0]) && capture_edge[0] |=> ir[0] ##1 ir[0] || !is_capture($past(fs[0])) || $past(wr_ctrl[0]))
        else $error("capture edge did not set flag");
    a_capture_mode: assert property ($past(!(is_pwc(fs[0]) || is_capture(fs[0]))) |-> !ir[0])
        else $error("capture flag set outside measuring modes");
    a_rmw_read: assert property (reg_read && reg_read_rmw && reg_addr == `REG_LOW_CTRL |=> reg_rdata[4] && reg_rdata[2])
        else $error("rmw read did not return ones");
    a_flag_clear: assert property (wr_ctrl[0] && !reg_wdata[4] && !ir_event[0] |=> !ir[0])
        else $error("write zero did not clear flag");
    a_upper_flags: assert property ($past(cascade) |-> !ir[1] && !flag[1])
        else $error("upper flags not zero in cascade");
    a_held_set: assert property (store_ok[0] |=> bf[0])
        else $error("store did not set result held");
    a_held_clear: assert property (!cascade && rd_data[0] && !store_ok[0] |=> !bf[0])
        else $error("data read did not clear result held");
    a_held_keeps: assert property (bf[0] && measure_done[0] && fs[0] != `FS_PWC_HIGH_CYCLE
                                   |=> $stable(compare_capture_data[7:0]))
        else $error("held data was overwritten");
    a_high_pulse: assert property (measure_done[0] && fs[0] == `FS_PWC_HIGH_CYCLE && measure_high_pulse[0]
                                   |=> compare_capture_data[7:0] == $past(measured_count[7:0]))
        else $error("high pulse result not transferred");
    a_cascade_read: assert property (cascade && rd_data[1] && !store_ok[0] |=> !bf[0])
        else $error("upper data read did not clear held");
    a_held_mode: assert property ($past(!is_pwc(fs[1])) |-> !bf[1])
        else $error("result held set outside pulse width");
    a_match_set: assert property (is_interval(fs[0]) && count_match[0] |=> flag[0])
        else $error("match did not set overflow flag");
    a_pwm_flag: assert property ($past(is_pwm_var(fs[0])) |-> !flag[0])
        else $error("overflow flag set in variable pwm");
    a_start_level: assert property (wr_ctrl[0] && reg_wdata[7] && run == 2'b00
                                    |=> timer_out_level[0] == $past(reg_wdata[1]))
        else $error("start did not load initial level");
    a_level_lock: assert property ((run[0] || run[1]) && wr_ctrl[0] |=> $stable(so[0]))
        else $error("initial level written while running");
    a_pin_drive: assert property (oe[1] |-> pin_oe[1] && pin_out[1] == timer_out_level[1])
        else $error("pin not driven by timer level");
    a_independent: assert property (!cascade && !pwm_pair && wr_ctrl[0] |=> $stable(run[1]))
        else $error("8-bit write disturbed other timer");

    c_pwc_hold: cover property (store_ok[0] ##1 bf[0] ##[1:20] rd_data[0]);
    c_cascade_run: cover property (cascade && wr_ctrl[0] && reg_wdata[7] ##[1:20] count_enable == 2'b11);
    c_irq: cover property (irq[0] ##[1:20] !irq[0]);
    c_suspend: cover property (count_enable[0] ##1 !count_enable[0] ##[1:20] count_enable[0]);

endmodule : dual_timer_status_control

// File: verif/tb_top.sv
// self-checking testbench for the timer pair status control block
`include "dual_timer_cfg.svh"
`define CHECK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dual_timer_pkg::*;

    // ==========================================================
    // signals
    logic clk_sys, reset_n, reg_write, reg_read, reg_read_rmw, width_select_16;
    reg_addr_t reg_addr;
    byte_t reg_wdata, reg_rdata;
    func_sel_t function_select_low, function_select_high;
    logic [1:0] overflow_irq_gate, measure_done, measure_high_pulse, capture_edge, count_match;
    logic [1:0] count_overflow, out_toggle, gpio_out, gpio_oe, count_enable, count_clear;
    logic [1:0] timer_out_level, pin_out, pin_oe, irq;
    logic [15:0] measured_count, compare_capture_data;
    int mismatches = 0;
    int checked = 0;

    dual_timer_status_control u_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_read_rmw(reg_read_rmw), .reg_rdata(reg_rdata),
        .function_select_low(function_select_low), .function_select_high(function_select_high),
        .overflow_irq_gate(overflow_irq_gate), .width_select_16(width_select_16),
        .measure_done(measure_done), .measure_high_pulse(measure_high_pulse), .capture_edge(capture_edge),
        .count_match(count_match), .count_overflow(count_overflow), .measured_count(measured_count),
        .out_toggle(out_toggle), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .count_enable(count_enable),
        .count_clear(count_clear), .compare_capture_data(compare_capture_data),
        .timer_out_level(timer_out_level), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq)
    );

    // ==========================================================
    // bus and event tasks
    task automatic wr(input reg_addr_t a, input byte_t d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        #1;
    endtask : wr

    // read data is looked at only in the cycle after the strobe
    task automatic rd(input reg_addr_t a, input logic rmw, input byte_t e, input string n, input byte_t m = 8'hFF);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        reg_read_rmw <= rmw;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        reg_read_rmw <= 1'b0;
        #1 `CHECK(n, e, reg_rdata & m)
    endtask : rd

    // one-cycle pulse on {measure_done, capture_edge, count_match, count_overflow, out_toggle}
    task automatic pulse(input logic [9:0] v);
        @(posedge clk_sys);
        {measure_done, capture_edge, count_match, count_overflow, out_toggle} <= v;
        @(posedge clk_sys);
        {measure_done, capture_edge, count_match, count_overflow, out_toggle} <= 10'h000;
        #1;
    endtask : pulse

    task automatic complete_run();
        if (mismatches == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // ==========================================================
    // clock and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // no wait in the sequence is open-ended, this only catches a stuck run
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        complete_run();
    end

    // ==========================================================
    // sequence
    initial begin
        reset_n = 1'b0;
        {reg_write, reg_read, reg_read_rmw, width_select_16} = 4'h0;
        reg_addr = `REG_LOW_CTRL;
        reg_wdata = 8'h00;
        {function_select_low, function_select_high} = 8'h00;
        {overflow_irq_gate, measure_high_pulse, measured_count} = 20'h00000;
        {measure_done, capture_edge, count_match, count_overflow, out_toggle} = 10'h000;
        gpio_out = 2'b10;
        gpio_oe = 2'b10;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        #1 `CHECK("clear after reset", 2'b11, count_clear)
        rd(`REG_LOW_CTRL, 1'b0, 8'h00, "low ctrl reset");
        // interval modes and 8-bit width are set before any run bit
        wr(`REG_LOW_CTRL, 8'h83);
        `CHECK("enable on start", 2'b01, count_enable)
        `CHECK("clear on start", 2'b10, count_clear)
        `CHECK("initial level", 1'b1, timer_out_level[0])
        `CHECK("pin enable", 2'b11, pin_oe)
        `CHECK("pin level", 2'b11, pin_out)
        pulse(10'h001);
        `CHECK("pin after toggle", 2'b10, pin_out)
        wr(`REG_LOW_CTRL, 8'h81);
        rd(`REG_LOW_CTRL, 1'b0, 8'h83, "low init blocked");
        wr(`REG_HIGH_CTRL, 8'h02);
        rd(`REG_HIGH_CTRL, 1'b0, 8'h00, "high init blocked");
        wr(`REG_LOW_CTRL, 8'hC3);
        `CHECK("suspended", 2'b00, count_enable)
        wr(`REG_LOW_CTRL, 8'h83);
        `CHECK("resumed", 2'b01, count_enable)
        pulse(10'h050);
        rd(`REG_LOW_CTRL, 1'b0, 8'h87, "match flag");
        wr(`REG_LOW_CTRL, 8'hA7);
        `CHECK("irq gated off", 2'b00, irq)
        @(posedge clk_sys);
        overflow_irq_gate <= 2'b01;
        #1 `CHECK("irq gated on", 2'b01, irq)
        rd(`REG_LOW_CTRL, 1'b1, 8'hB7, "rmw read");
        wr(`REG_LOW_CTRL, 8'hA3);
        `CHECK("irq after clear", 2'b00, irq)
        rd(`REG_LOW_CTRL, 1'b0, 8'hA3, "flag cleared");
        wr(`REG_LOW_CTRL, 8'h03);
        `CHECK("stop clears", 2'b11, count_clear)
        // capture mode: capture flag raises irq without the gate
        @(posedge clk_sys);
        function_select_low <= 4'hC;
        overflow_irq_gate <= 2'b00;
        wr(`REG_LOW_CTRL, 8'h20);
        pulse(10'h040);
        `CHECK("capture irq", 2'b01, irq)
        pulse(10'h004);
        rd(`REG_LOW_CTRL, 1'b0, 8'h34, "capture flags");
        wr(`REG_LOW_CTRL, 8'h20);
        `CHECK("irq cleared", 2'b00, irq)
        // pulse width, 8-bit: a held result blocks new stores except a high pulse in the combined code
        @(posedge clk_sys);
        function_select_low <= 4'h8;
        measured_count <= 16'h005A;
        wr(`REG_LOW_CTRL, 8'h00);
        pulse(10'h100);
        `CHECK("first store", 8'h5A, compare_capture_data[7:0])
        rd(`REG_LOW_CTRL, 1'b0, 8'h18, "held set");
        @(posedge clk_sys);
        measured_count <= 16'h0033;
        pulse(10'h100);
        `CHECK("store refused", 8'h5A, compare_capture_data[7:0])
        rd(`REG_LOW_DATA, 1'b0, 8'h5A, "low data");
        wr(`REG_LOW_CTRL, 8'h18);
        rd(`REG_LOW_CTRL, 1'b0, 8'h10, "held read clear");
        pulse(10'h100);
        `CHECK("store accepted", 8'h33, compare_capture_data[7:0])
        @(posedge clk_sys);
        function_select_low <= 4'h9;
        measure_high_pulse <= 2'b01;
        measured_count <= 16'h0077;
        pulse(10'h100);
        `CHECK("high pulse stored", 8'h77, compare_capture_data[7:0])
        @(posedge clk_sys);
        measure_high_pulse <= 2'b00;
        measured_count <= 16'h0066;
        pulse(10'h100);
        `CHECK("cycle refused", 8'h77, compare_capture_data[7:0])
        @(posedge clk_sys);
        function_select_low <= 4'h0;
        rd(`REG_LOW_CTRL, 1'b0, 8'h00, "flags outside pwc");
        // variable pwm links run and suspend of both timers
        @(posedge clk_sys);
        {function_select_low, function_select_high} <= 8'h44;
        wr(`REG_HIGH_CTRL, 8'h80);
        `CHECK("pwm start", 2'b11, count_enable)
        wr(`REG_HIGH_CTRL, 8'hC0);
        `CHECK("pwm suspend", 2'b00, count_enable)
        pulse(10'h030);
        rd(`REG_LOW_CTRL, 1'b0, 8'hC0, "pwm mirror");
        wr(`REG_LOW_CTRL, 8'h00);
        `CHECK("pwm stop", 2'b11, count_clear)
        rd(`REG_HIGH_CTRL, 1'b0, 8'h00, "pwm high stop");
        // 16-bit cascade in pulse width mode
        @(posedge clk_sys);
        width_select_16 <= 1'b1;
        {function_select_low, function_select_high} <= 8'h88;
        measured_count <= 16'hBEEF;
        wr(`REG_LOW_CTRL, 8'h80);
        `CHECK("cascade run", 2'b11, count_enable)
        pulse(10'h108);
        `CHECK("cascade store", 16'hBEEF, compare_capture_data)
        rd(`REG_HIGH_CTRL, 1'b0, 8'h00, "upper flags", 8'h14);
        rd(`REG_LOW_CTRL, 1'b0, 8'h08, "cascade held", 8'h08);
        rd(`REG_HIGH_DATA, 1'b0, 8'hBE, "high data");
        rd(`REG_LOW_CTRL, 1'b0, 8'h00, "held by high read", 8'h08);
        wr(`REG_HIGH_CTRL, 8'h00);
        `CHECK("cascade stop", 2'b11, count_clear)
        complete_run();
    end

endmodule : tb_top
